// File: hw/vtsc_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "vtsc_cfg.svh"

module vtsc_top (
  input  wire  logic                             core_clk,
  input  wire  logic                             rst_b,
  input  wire  logic [7:0]                       reg_addr,
  input  wire  logic [7:0]                       reg_wdata,
  input  wire  logic                             reg_wr,
  input  wire  logic                             reg_rd,
  output logic       [7:0]                       reg_rdata,
  input  wire  logic                             frame_sync,
  input  wire  vtsc_pkg::vtsc_video_t [1:0]      port_video
);

  // ----------------------------------------
  // State and local signals
  // ----------------------------------------
  vtsc_pkg::vtsc_top_st_t st_r;
  vtsc_pkg::vtsc_top_st_t st_nxt;
  logic [15:0]            stamp_count;
  logic [1:0]             trk_fire;
  logic [1:0]             cap_en;
  logic [1:0]             frame_starts;
  logic [15:0]            line_sel;
  logic                   sync_sel;
  logic                   trig_mode;
  logic                   free_run;
  logic                   early_sel;
  logic                   hold;
  logic                   fs_edge;
  logic                   ctl_wr;
  logic                   hold_set;
  logic                   hold_rel;
  logic                   boundary;
  logic                   all_ok;
  logic [1:0]             en_nxt;

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  function automatic logic [7:0] vtsc_read_byte(input logic [7:0]             addr,
                                                input vtsc_pkg::vtsc_top_st_t s);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `VTSC_ADDR_CONFIG:  v = s.config_reg;
      `VTSC_ADDR_CONTROL: v = s.control_reg;
      `VTSC_ADDR_LINE_UP: v = s.line_upper;
      `VTSC_ADDR_LINE_LO: v = s.line_lower;
      `VTSC_ADDR_STATUS: begin
        v[`VTSC_STS_READY_BIT]      = s.ready;
        v[`VTSC_STS_VALID_LSB +: 2] = s.valid;
      end
      `VTSC_ADDR_P0_UP:   v = s.stamp[0][15:8];
      `VTSC_ADDR_P0_LO:   v = s.stamp[0][7:0];
      `VTSC_ADDR_P1_UP:   v = s.stamp[1][15:8];
      `VTSC_ADDR_P1_LO:   v = s.stamp[1][7:0];
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Configuration fields
  // ----------------------------------------
  // Field views of the software registers
  assign sync_sel  = st_r.config_reg[`VTSC_CFG_EDGE_BIT];
  assign trig_mode = st_r.config_reg[`VTSC_CFG_MODE_BIT];
  assign free_run  = st_r.config_reg[`VTSC_CFG_FREE_BIT];
  assign early_sel = st_r.config_reg[`VTSC_CFG_EARLY_BIT];
  assign hold      = st_r.control_reg[`VTSC_CTL_HOLD_BIT];
  assign cap_en    = st_r.control_reg[`VTSC_CTL_EN_LSB +: 2];
  assign line_sel  = {st_r.line_upper, st_r.line_lower};

  // Active frame sync edge from the previous sample
  assign fs_edge = sync_sel ? (st_r.sync_prev & ~frame_sync)
                            : (~st_r.sync_prev & frame_sync);

  // Control writes that set or release the hold
  assign ctl_wr   = reg_wr && (reg_addr == `VTSC_ADDR_CONTROL);
  assign hold_set = ctl_wr && reg_wdata[`VTSC_CTL_HOLD_BIT];
  assign hold_rel = ctl_wr && !reg_wdata[`VTSC_CTL_HOLD_BIT] && hold;

  // Frame boundary that releases ready in normal operation
  assign frame_starts = {port_video[1].frame_start, port_video[0].frame_start};
  assign boundary     = free_run ? |(frame_starts & cap_en) : fs_edge;

  // ----------------------------------------
  // Timestamp counter and per-port trackers
  // ----------------------------------------
  vtsc_tick_gen u_tick (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .res_sel     (st_r.config_reg[`VTSC_CFG_RES_LSB +: 2]),
    .stamp_count (stamp_count)
  );

  for (genvar p = 0; p < 2; p++) begin : g_port
    vtsc_port_track u_trk (
      .core_clk    (core_clk),
      .rst_b       (rst_b),
      .line_start  (port_video[p].line_start),
      .frame_start (port_video[p].frame_start),
      .fsync_evt   (fs_edge),
      .cap_enable  (cap_en[p]),
      .trig_mode   (trig_mode),
      .free_run    (free_run),
      .hold        (hold),
      .line_sel    (line_sel),
      .cap_pulse   (trk_fire[p])
    );
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.sync_prev = frame_sync;
    // Software register writes, reserved bits stay zero
    if (reg_wr) begin
      case (reg_addr)
        `VTSC_ADDR_CONFIG:  st_nxt.config_reg  = reg_wdata & `VTSC_CFG_WMASK;
        `VTSC_ADDR_CONTROL: st_nxt.control_reg = reg_wdata & `VTSC_CTL_WMASK;
        `VTSC_ADDR_LINE_UP: st_nxt.line_upper  = reg_wdata;
        `VTSC_ADDR_LINE_LO: st_nxt.line_lower  = reg_wdata;
        default: begin
        end
      endcase
    end
    // Latch the counter for each enabled port, never while held
    for (int i = 0; i < 2; i++) begin
      if (trk_fire[i] && cap_en[i] && !hold) begin
        st_nxt.stamp[i] = stamp_count;
        st_nxt.valid[i] = 1'b1;
      end
    end
    // Leaving hold starts a fresh capture round
    if (hold_rel) begin
      st_nxt.valid = 2'h0;
    end
    // Round complete: judged on next valid bits and next enables, so enabling a port with no valid stamp drops ready
    en_nxt = st_nxt.control_reg[`VTSC_CTL_EN_LSB +: 2];
    all_ok = (en_nxt != 2'h0) && ((st_nxt.valid & en_nxt) == en_nxt);
    // Ready flag: early or at the next frame boundary
    if (hold_set || hold_rel || !all_ok) begin
      st_nxt.ready = 1'b0;
    end else if (!hold && (early_sel || boundary)) begin
      st_nxt.ready = 1'b1;
    end
    // Read data stand for one cycle only
    st_nxt.rdata = reg_rd ? vtsc_read_byte(reg_addr, st_r) : 8'h00;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r             <= '0;
      st_r.config_reg  <= `VTSC_REG_RST;
      st_r.control_reg <= `VTSC_REG_RST;
      st_r.line_upper  <= `VTSC_REG_RST;
      st_r.line_lower  <= `VTSC_REG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_EDGE_POL: assert property (
    $past(rst_b) && fs_edge
      |-> $changed(frame_sync) && (frame_sync == !sync_sel))
    else $error("frame sync edge of wrong polarity");

  AST_SYNC_CAPTURE: assert property (
    fs_edge && trig_mode && !free_run && cap_en[0] && !hold && !reg_wr ##1
      !hold && cap_en[0] |=> st_r.valid[0] && st_r.stamp[0] == $past(stamp_count))
    else $error("frame sync did not capture port 0");

  AST_READY_EARLY: assert property (
    early_sel && !hold && !reg_wr && all_ok |=> st_r.ready)
    else $error("early ready not raised");

  AST_READY_COVER: assert property (
    st_r.ready |-> (cap_en != 2'h0) && ((st_r.valid & cap_en) == cap_en))
    else $error("ready raised before every enabled port captured");

  AST_HOLD_CLEARS: assert property (
    hold_set |=> !st_r.ready && hold)
    else $error("hold write did not clear ready");

  AST_HOLD_KEEPS: assert property (
    hold ##1 1'b1 |-> $stable(st_r.stamp))
    else $error("stamp changed while held");

  AST_PORT_DISABLED: assert property (
    !cap_en[1] && !hold_rel |=> !$rose(st_r.valid[1]))
    else $error("disabled port captured");

  AST_READ_STAMP: assert property (
    reg_rd && reg_addr == `VTSC_ADDR_P1_LO |=> reg_rdata == $past(st_r.stamp[1][7:0]))
    else $error("port 1 lower stamp byte misread");

  AST_READ_STATUS: assert property (
    reg_rd && reg_addr == `VTSC_ADDR_STATUS |=>
      reg_rdata == {3'h0, $past(st_r.ready), 2'h0, $past(st_r.valid)})
    else $error("status read wrong");

  AST_READ_ONE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

  AST_EDGE_SEEN: assert property (
    $past(rst_b) && $changed(frame_sync) && (frame_sync != sync_sel)
      |-> fs_edge)
    else $error("active frame sync edge not detected");

  AST_READY_NORMAL: assert property (
    !early_sel && !boundary && !st_r.ready
      |=> !st_r.ready)
    else $error("normal ready raised off a frame boundary");

  AST_READY_DROP: assert property (
    !all_ok
      |=> !st_r.ready)
    else $error("ready kept with an enabled port empty");

  AST_READY_FROZEN: assert property (
    hold && !st_r.ready
      |=> !st_r.ready)
    else $error("ready raised while held");

  AST_HOLD_RELEASE: assert property (
    hold_rel
      |=> (st_r.valid == 2'h0) && !st_r.ready)
    else $error("hold release did not restart the round");

  AST_STAMP_LATCH: assert property (
    trk_fire[1] && cap_en[1] && !hold
      |=> st_r.valid[1] && (st_r.stamp[1] == $past(stamp_count)))
    else $error("port 1 stamp not latched from the counter");

  AST_NO_CAPTURE_OFF: assert property (
    !cap_en[0]
      |=> $stable(st_r.stamp[0]))
    else $error("disabled port 0 stamp changed");

  AST_CFG_WRITE: assert property (
    reg_wr && (reg_addr == `VTSC_ADDR_CONFIG)
      |=> st_r.config_reg == ($past(reg_wdata) & `VTSC_CFG_WMASK))
    else $error("config write not stored");

  AST_CTL_WRITE: assert property (
    reg_wr && (reg_addr == `VTSC_ADDR_CONTROL)
      |=> st_r.control_reg == ($past(reg_wdata) & `VTSC_CTL_WMASK))
    else $error("control write not stored");

  AST_LINE_WRITE: assert property (
    reg_wr && (reg_addr == `VTSC_ADDR_LINE_LO)
      |=> line_sel[7:0] == $past(reg_wdata))
    else $error("capture line lower byte not stored");

  AST_READ_LINE: assert property (
    reg_rd && (reg_addr == `VTSC_ADDR_LINE_UP)
      |=> reg_rdata == $past(line_sel[15:8]))
    else $error("capture line upper byte misread");

  AST_READ_P0: assert property (
    reg_rd && (reg_addr == `VTSC_ADDR_P0_UP)
      |=> reg_rdata == $past(st_r.stamp[0][15:8]))
    else $error("port 0 upper stamp byte misread");

  COV_LINE_CAPTURE: cover property (!trig_mode ##0 trk_fire[0] ##1 st_r.valid[0]);
  COV_FREERUN_CAPTURE: cover property (trig_mode && free_run ##0 trk_fire[0]);
  COV_READY_NORMAL: cover property (!early_sel && $rose(st_r.ready));
  COV_HOLD_AFTER_READY: cover property (st_r.ready ##1 hold_set);

endmodule

// File: hw/vtsc_cfg.svh
`ifndef VTSC_CFG_SVH
`define VTSC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VTSC_ADDR_CONFIG    8'h25
`define VTSC_ADDR_CONTROL   8'h26
`define VTSC_ADDR_LINE_UP   8'h27
`define VTSC_ADDR_LINE_LO   8'h28
`define VTSC_ADDR_STATUS    8'h29
`define VTSC_ADDR_P0_UP     8'h2A
`define VTSC_ADDR_P0_LO     8'h2B
`define VTSC_ADDR_P1_UP     8'h2C
`define VTSC_ADDR_P1_LO     8'h2D

// ----------------------------------------
// Field positions, masks and reset values
// ----------------------------------------
`define VTSC_CFG_MODE_BIT   0
`define VTSC_CFG_FREE_BIT   1
`define VTSC_CFG_EARLY_BIT  3
`define VTSC_CFG_RES_LSB    4
`define VTSC_CFG_EDGE_BIT   6
`define VTSC_CFG_WMASK      8'h7B
`define VTSC_CTL_EN_LSB     0
`define VTSC_CTL_HOLD_BIT   4
`define VTSC_CTL_WMASK      8'h13
`define VTSC_STS_VALID_LSB  0
`define VTSC_STS_READY_BIT  4
`define VTSC_REG_RST        8'h00

// ----------------------------------------
// Tick periods
// ----------------------------------------
`define VTSC_CLK_PS         8000
`define VTSC_TICK00_PS      40000
`define VTSC_TICK01_PS      80000
`define VTSC_TICK10_PS      160000
`define VTSC_TICK11_PS      1000000
`define VTSC_TICK00_CYC     (`VTSC_TICK00_PS / `VTSC_CLK_PS)
`define VTSC_TICK01_CYC     (`VTSC_TICK01_PS / `VTSC_CLK_PS)
`define VTSC_TICK10_CYC     (`VTSC_TICK10_PS / `VTSC_CLK_PS)
`define VTSC_TICK11_CYC     (`VTSC_TICK11_PS / `VTSC_CLK_PS)

`endif

// File: hw/vtsc_pkg.sv
package vtsc_pkg;

  // Video timing of one receive port
  typedef struct packed {
    logic line_start;
    logic frame_start;
  } vtsc_video_t;

  // Free-run frame start search
  typedef enum logic {VTSC_TRK_SEEK, VTSC_TRK_ARMED} vtsc_trk_t;

  typedef struct packed {
    logic [6:0]  div;
    logic [15:0] count;
  } vtsc_tick_st_t;

  typedef struct packed {
    vtsc_trk_t   trk;
    logic [15:0] line_cnt;
    logic        fire;
  } vtsc_trk_st_t;

  typedef struct packed {
    logic [7:0]       config_reg;
    logic [7:0]       control_reg;
    logic [7:0]       line_upper;
    logic [7:0]       line_lower;
    logic             sync_prev;
    logic [1:0]       valid;
    logic             ready;
    logic [1:0][15:0] stamp;
    logic [7:0]       rdata;
  } vtsc_top_st_t;

endpackage

// File: hw/vtsc_tick_gen.sv
`timescale 1ns/100ps
`include "vtsc_cfg.svh"

module vtsc_tick_gen (
  input  wire  logic        core_clk,
  input  wire  logic        rst_b,
  input  wire  logic [1:0]  res_sel,
  output logic       [15:0] stamp_count
);

  vtsc_pkg::vtsc_tick_st_t st_r;
  vtsc_pkg::vtsc_tick_st_t st_nxt;

  // Divider length in clock cycles for each resolution code
  function automatic logic [6:0] vtsc_period(input logic [1:0] sel);
    case (sel)
      2'h0:    vtsc_period = 7'(`VTSC_TICK00_CYC);
      2'h1:    vtsc_period = 7'(`VTSC_TICK01_CYC);
      2'h2:    vtsc_period = 7'(`VTSC_TICK10_CYC);
      default: vtsc_period = 7'(`VTSC_TICK11_CYC);
    endcase
  endfunction

  // Prescaler and free-running 16-bit counter, wraps after 65535
  always_comb begin
    st_nxt = st_r;
    if (st_r.div >= 7'(vtsc_period(res_sel) - 7'h01)) begin
      st_nxt.div   = 7'h00;
      st_nxt.count = 16'(st_r.count + 16'h0001);
    end else begin
      st_nxt.div = 7'(st_r.div + 7'h01);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stamp_count = st_r.count;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_TICK_DIV: assert property (
    $changed(st_r.count) && $past(rst_b) && $stable(res_sel) &&
      $past(res_sel) == $past(res_sel, 2) |->
      $past(st_r.div) == 7'(vtsc_period(res_sel) - 7'h01))
    else $error("counter advanced off the tick period");
  AST_TICK_STEP: assert property (
    $changed(st_r.count) && $past(rst_b) |-> st_r.count == 16'($past(st_r.count) + 16'h0001))
    else $error("counter did not step by one");

endmodule

// File: hw/vtsc_port_track.sv
`timescale 1ns/100ps

module vtsc_port_track (
  input  wire  logic        core_clk,
  input  wire  logic        rst_b,
  input  wire  logic        line_start,
  input  wire  logic        frame_start,
  input  wire  logic        fsync_evt,
  input  wire  logic        cap_enable,
  input  wire  logic        trig_mode,
  input  wire  logic        free_run,
  input  wire  logic        hold,
  input  wire  logic [15:0] line_sel,
  output logic              cap_pulse
);

  vtsc_pkg::vtsc_trk_st_t st_r;
  vtsc_pkg::vtsc_trk_st_t st_nxt;
  logic [15:0]            line_next;
  logic                   line_hit;
  logic                   frame_hit;

  // Line counting and trigger selection
  assign line_next = 16'(st_r.line_cnt + 16'h0001);
  assign line_hit  = line_start && !frame_start && (line_next == line_sel);
  assign frame_hit = free_run ? (frame_start && st_r.trk == vtsc_pkg::VTSC_TRK_ARMED)
                              : fsync_evt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.fire = cap_enable && !hold && (trig_mode ? frame_hit : line_hit);
    if (line_start) begin
      st_nxt.line_cnt = line_next;
    end
    // Free-run search arms once the programmed line is reached
    case (st_r.trk)
      vtsc_pkg::VTSC_TRK_SEEK: begin
        if (line_start && line_next >= line_sel) begin
          st_nxt.trk = vtsc_pkg::VTSC_TRK_ARMED;
        end
      end
      vtsc_pkg::VTSC_TRK_ARMED: begin
      end
      default: begin
        st_nxt.trk = vtsc_pkg::VTSC_TRK_SEEK;
      end
    endcase
    if (frame_start) begin
      st_nxt.line_cnt = 16'h0000;
      st_nxt.trk      = vtsc_pkg::VTSC_TRK_SEEK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= '{trk: vtsc_pkg::VTSC_TRK_SEEK, line_cnt: 16'h0000, fire: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cap_pulse = st_r.fire;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_LINE_HIT: assert property (
    line_start && !frame_start && !trig_mode && cap_enable && !hold &&
      line_next == line_sel |=> cap_pulse)
    else $error("line start capture missed");
  AST_FRAME_SYNC: assert property (
    trig_mode && !free_run && fsync_evt && cap_enable && !hold |=> cap_pulse)
    else $error("frame sync capture missed");
  AST_FREERUN_WAIT: assert property (
    trig_mode && free_run && frame_start && st_r.trk == vtsc_pkg::VTSC_TRK_SEEK |=> !cap_pulse)
    else $error("free-run capture before programmed line");

endmodule

// File: tb/vtsc_video_model.sv
`timescale 1ns/100ps

module vtsc_video_model #(
  parameter int LINES = 4,
  parameter int GAP   = 4
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic [1:0]                  frame_go,
  input  wire logic                        sync_level,
  output vtsc_pkg::vtsc_video_t [1:0]      port_video,
  output logic                             frame_sync
);
  // ----------------------------------------
  // Receive-port line timing and frame sync
  // ----------------------------------------
  int cnt [2];

  // Each go pulse starts one frame: a frame start, then LINES lines GAP cycles apart
  always_ff @(posedge core_clk) begin
    frame_sync <= sync_level;
    for (int i = 0; i < 2; i++) begin
      port_video[i].frame_start <= frame_go[i];
      port_video[i].line_start  <= 1'b0;
      if (!rst_b) begin
        cnt[i] <= 0;
      end else if (frame_go[i]) begin
        cnt[i] <= 1;
      end else if (cnt[i] != 0) begin
        cnt[i]                   <= (cnt[i] == LINES * GAP) ? 0 : cnt[i] + 1;
        port_video[i].line_start <= (cnt[i] % GAP == 0);
      end
    end
  end
endmodule

// File: tb/video_timestamp_capture_test.sv
`timescale 1ns/100ps
`include "vtsc_cfg.svh"

module video_timestamp_capture_test;
  logic                        core_clk;
  logic                        rst_b;
  logic [7:0]                  reg_addr;
  logic [7:0]                  reg_wdata;
  logic                        reg_wr;
  logic                        reg_rd;
  logic [7:0]                  reg_rdata;
  logic                        frame_sync;
  vtsc_pkg::vtsc_video_t [1:0] port_video;
  logic [1:0]                  frame_go;
  logic                        sync_level;
  int                          fail_count;
  int                          checked;
  int                          cycles;
  logic [15:0]                 s0;
  logic [15:0]                 s1;

  vtsc_top i_dut (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .frame_sync (frame_sync),
    .port_video (port_video)
  );

  vtsc_video_model i_video (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .frame_go   (frame_go),
    .sync_level (sync_level),
    .port_video (port_video),
    .frame_sync (frame_sync)
  );

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Cuts the run short if a wait never ends
  always @(posedge core_clk) begin
    cycles <= rst_b ? cycles + 1 : 0;
    if (cycles == 20000) begin
      $display("ERROR %0t: run took too long", $time);
      fail_count++;
      results();
    end
  end

  // ----------------------------------------
  // Register bus and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp({8'h00, d}, {8'h00, exp});
  endtask

  task automatic stamp(input logic [7:0] a, output logic [15:0] v);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(a, hi);
    rd(a + 8'h01, lo);
    v = {hi, lo};
  endtask

  // One frame on a port: a one-cycle go pulse, the caller waits for its lines
  task automatic frame(input int p);
    @(posedge core_clk);
    frame_go[p] <= 1'b1;
    @(posedge core_clk);
    frame_go[p] <= 1'b0;
  endtask

  task automatic sync(input logic lvl);
    @(posedge core_clk);
    sync_level <= lvl;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic results();
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_b      = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    frame_go   = 2'b00;
    sync_level = 1'b0;
    fail_count = 0;
    checked    = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place included
    for (int a = 8'h25; a <= 8'h2E; a++) begin
      chk(a[7:0], 8'h00);
    end
    // Free-run frame mode: first frame only arms, second captures
    wr(`VTSC_ADDR_LINE_LO, 8'h02);
    wr(`VTSC_ADDR_CONFIG, 8'h0B);
    wr(`VTSC_ADDR_CONTROL, 8'h01);
    frame(0);
    repeat (24) @(posedge core_clk);
    chk(`VTSC_ADDR_STATUS, 8'h00);
    frame(0);
    repeat (24) @(posedge core_clk);
    chk(`VTSC_ADDR_STATUS, 8'h11);
    wr(`VTSC_ADDR_CONTROL, 8'h11);
    wr(`VTSC_ADDR_CONTROL, 8'h00);
    // Write masks and read-only places
    wr(`VTSC_ADDR_CONFIG, 8'hFF);
    chk(`VTSC_ADDR_CONFIG, 8'h7B);
    wr(`VTSC_ADDR_CONTROL, 8'hFF);
    chk(`VTSC_ADDR_CONTROL, 8'h13);
    wr(`VTSC_ADDR_CONTROL, 8'h00);
    wr(`VTSC_ADDR_STATUS, 8'hFF);
    wr(`VTSC_ADDR_P0_UP, 8'hFF);
    wr(8'h30, 8'hFF);
    chk(`VTSC_ADDR_STATUS, 8'h00);
    chk(`VTSC_ADDR_P0_UP, 8'h00);
    chk(8'h30, 8'h00);
    wr(`VTSC_ADDR_LINE_UP, 8'h01);
    chk(`VTSC_ADDR_LINE_UP, 8'h01);
    // Line mode at line 0x0102 is never reached by a short frame
    wr(`VTSC_ADDR_CONFIG, 8'h00);
    wr(`VTSC_ADDR_CONTROL, 8'h01);
    frame(0);
    repeat (24) @(posedge core_clk);
    chk(`VTSC_ADDR_STATUS, 8'h00);
    wr(`VTSC_ADDR_LINE_UP, 8'h00);
    // Each tick code: ports triggered 1000 cycles apart differ by 1000 / tick
    for (int c = 0; c < 4; c++) begin
      wr(`VTSC_ADDR_CONFIG, {2'b00, c[1:0], 4'h0});
      wr(`VTSC_ADDR_CONTROL, 8'h03);
      frame(0);
      repeat (998) @(posedge core_clk);
      frame(1);
      repeat (24) @(posedge core_clk);
      wr(`VTSC_ADDR_CONTROL, 8'h13);
      chk(`VTSC_ADDR_STATUS, 8'h03);
      stamp(`VTSC_ADDR_P0_UP, s0);
      stamp(`VTSC_ADDR_P1_UP, s1);
      cmp(s1 - s0, 16'(1000 / (c == 0 ? 5 : c == 1 ? 10 : c == 2 ? 20 : 125)));
      frame(0);
      repeat (24) @(posedge core_clk);
      stamp(`VTSC_ADDR_P0_UP, s1);
      cmp(s1, s0);
      wr(`VTSC_ADDR_CONTROL, 8'h00);
    end
    // Frame sync, rising edge, early ready, port 1 disabled
    wr(`VTSC_ADDR_CONFIG, 8'h09);
    wr(`VTSC_ADDR_CONTROL, 8'h01);
    sync(1'b1);
    chk(`VTSC_ADDR_STATUS, 8'h11);
    wr(`VTSC_ADDR_CONTROL, 8'h11);
    chk(`VTSC_ADDR_STATUS, 8'h01);
    wr(`VTSC_ADDR_CONTROL, 8'h01);
    // Falling polarity: fall captures, rise does not
    wr(`VTSC_ADDR_CONFIG, 8'h49);
    sync(1'b0);
    chk(`VTSC_ADDR_STATUS, 8'h11);
    wr(`VTSC_ADDR_CONTROL, 8'h11);
    wr(`VTSC_ADDR_CONTROL, 8'h01);
    sync(1'b1);
    chk(`VTSC_ADDR_STATUS, 8'h00);
    // Normal ready: set at the frame boundary after capture
    wr(`VTSC_ADDR_CONFIG, 8'h41);
    sync(1'b0);
    chk(`VTSC_ADDR_STATUS, 8'h01);
    sync(1'b1);
    sync(1'b0);
    chk(`VTSC_ADDR_STATUS, 8'h11);
    results();
  end
endmodule
